// File: logic/tx_frame_maint.sv
// transmit frame generator maintenance: overhead insertion, alarms, overwrites and error injection
`timescale 1ns/1ps
`default_nettype none
module tx_frame_maint (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic red_alarm,
    input wire logic in_valid,
    input wire logic in_bit,
    output logic out_valid,
    output logic out_bit,
    output logic irq
);
    // registers
    logic gen_off;
    logic bypass;
    tx_fgen_pkg::frame_fmt_e fmt;
    logic [5:0] slc_sa;
    logic manual_yel;
    logic auto_yel;
    logic force_ones;
    logic force_zeros;
    logic align_toggle;
    logic copy_en;
    logic [1:0] irq_en;
    logic [1:0] flags;
    logic [3:0] inject;
    logic [3:0] inject_prev;
    logic [3:0] armed;
    logic align_prev;

    // framing state
    logic [7:0] bit_pos;
    logic [6:0] frame_num;
    logic last_f;
    logic [3:0] dl_cnt;
    logic crc_run;
    logic align_pend;
    logic align_dir;

    // bus
    logic ack;
    logic [7:0] idx;
    logic wr_go;
    logic [7:0] wdat;

    function automatic logic [6:0] mf_len(input tx_fgen_pkg::frame_fmt_e f);
        unique case (f)
            tx_fgen_pkg::FMT_SF: mf_len = tx_fgen_pkg::MF_SF;
            tx_fgen_pkg::FMT_ESF: mf_len = tx_fgen_pkg::MF_ESF;
            tx_fgen_pkg::FMT_DM: mf_len = tx_fgen_pkg::MF_SF;
            tx_fgen_pkg::FMT_SLC: mf_len = tx_fgen_pkg::MF_SLC;
        endcase
    endfunction

    assign idx = avs_address[9:2];
    assign wdat = avs_writedata[7:0];
    // one wait state: the request is decoded in the first cycle and served in the second
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr_go = avs_write & ack;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack) begin
            unique case (idx)
                tx_fgen_pkg::IDX_MODE:
                    avs_readdata <= {26'h0, fmt, 1'b0, bypass, 1'b0, gen_off};
                tx_fgen_pkg::IDX_SLC_SA:
                    avs_readdata <= {26'h0, slc_sa};
                tx_fgen_pkg::IDX_ALARM:
                    avs_readdata <= {30'h0, auto_yel, manual_yel};
                tx_fgen_pkg::IDX_OVERWRITE:
                    avs_readdata <= {28'h0, copy_en, align_toggle, force_zeros, force_ones};
                tx_fgen_pkg::IDX_IRQ_EN:
                    avs_readdata <= {30'h0, irq_en};
                tx_fgen_pkg::IDX_IRQ_FLAGS:
                    avs_readdata <= {30'h0, flags};
                tx_fgen_pkg::IDX_INJECT:
                    avs_readdata <= {28'h0, inject};
                default:
                    avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            gen_off <= 1'b0;
            bypass <= 1'b0;
            fmt <= tx_fgen_pkg::FMT_SF;
            slc_sa <= 6'h00;
            manual_yel <= 1'b0;
            auto_yel <= 1'b0;
            force_ones <= 1'b0;
            force_zeros <= 1'b0;
            align_toggle <= 1'b0;
            copy_en <= 1'b0;
            irq_en <= 2'h0;
        end else if (wr_go) begin
            unique case (idx)
                tx_fgen_pkg::IDX_MODE: begin
                    gen_off <= wdat[tx_fgen_pkg::B_GEN_OFF];
                    bypass <= wdat[tx_fgen_pkg::B_BYPASS];
                    fmt <= tx_fgen_pkg::frame_fmt_e'(wdat[tx_fgen_pkg::B_FMT_LO +: 2]);
                end
                tx_fgen_pkg::IDX_SLC_SA: slc_sa <= wdat[5:0];
                tx_fgen_pkg::IDX_ALARM: begin
                    manual_yel <= wdat[tx_fgen_pkg::B_MANUAL_YEL];
                    auto_yel <= wdat[tx_fgen_pkg::B_AUTO_YEL];
                end
                tx_fgen_pkg::IDX_OVERWRITE: begin
                    force_ones <= wdat[tx_fgen_pkg::B_FORCE_ONES];
                    force_zeros <= wdat[tx_fgen_pkg::B_FORCE_ZEROS];
                    align_toggle <= wdat[tx_fgen_pkg::B_ALIGN];
                    copy_en <= wdat[tx_fgen_pkg::B_COPY];
                end
                tx_fgen_pkg::IDX_IRQ_EN: irq_en <= wdat[1:0];
                default: ;
            endcase
        end
    end

    // position decode for the bit now entering
    logic f_pos;
    logic odd_frame;
    logic [5:0] pair_idx;
    logic [1:0] esf_phase;
    logic [3:0] esf_grp;
    logic gen_on;
    logic sf_like;
    logic yellow;
    logic frame_first;
    logic mf_first;

    assign f_pos = (bit_pos == 8'd0);
    assign odd_frame = ~frame_num[0];
    assign pair_idx = frame_num[6:1];
    assign esf_phase = frame_num[1:0];
    assign esf_grp = frame_num[5:2];
    assign gen_on = ~gen_off;
    assign sf_like = (fmt != tx_fgen_pkg::FMT_ESF);
    assign yellow = manual_yel | (auto_yel & red_alarm);
    assign frame_first = in_valid & f_pos;
    assign mf_first = frame_first & (frame_num == 7'd0);

    // injection points reached by the current bit
    logic at_ft;
    logic at_fs;
    logic at_crc;
    logic at_dds;
    logic [3:0] done;

    assign at_ft = in_valid & f_pos & gen_on & sf_like & odd_frame;
    always_comb begin
        at_fs = 1'b0;
        if (in_valid & f_pos & gen_on) begin
            unique case (fmt)
                tx_fgen_pkg::FMT_SF,
                tx_fgen_pkg::FMT_DM: at_fs = ~odd_frame;
                tx_fgen_pkg::FMT_ESF: at_fs = (esf_phase == tx_fgen_pkg::ESF_FAS_PHASE);
                tx_fgen_pkg::FMT_SLC: at_fs = ~odd_frame & (pair_idx < tx_fgen_pkg::SLC_SYNC_LEN);
            endcase
        end
    end
    assign at_crc = in_valid & f_pos & gen_on & (fmt == tx_fgen_pkg::FMT_ESF)
                    & (esf_phase == tx_fgen_pkg::ESF_CRC_PHASE)
                    & (armed[tx_fgen_pkg::B_CRC] | crc_run);
    assign at_dds = in_valid & gen_on & (fmt == tx_fgen_pkg::FMT_DM)
                    & (bit_pos >= tx_fgen_pkg::DDS_FIRST) & (bit_pos <= tx_fgen_pkg::DDS_LAST)
                    & armed[tx_fgen_pkg::B_DDS];

    // an inversion only starts at a pattern's first bit, so exactly one whole pattern flips
    logic dds_go;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dds_go <= 1'b0;
        end else if (at_dds & (bit_pos == tx_fgen_pkg::DDS_FIRST)) begin
            dds_go <= 1'b1;
        end else if (at_dds & (bit_pos == tx_fgen_pkg::DDS_LAST)) begin
            dds_go <= 1'b0;
        end
    end

    always_comb begin
        done = 4'h0;
        done[tx_fgen_pkg::B_FT] = at_ft & armed[tx_fgen_pkg::B_FT];
        done[tx_fgen_pkg::B_FS] = at_fs & armed[tx_fgen_pkg::B_FS];
        done[tx_fgen_pkg::B_CRC] = at_crc & crc_run & (esf_grp == 4'd5);
        done[tx_fgen_pkg::B_DDS] = at_dds & dds_go & (bit_pos == tx_fgen_pkg::DDS_LAST);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            crc_run <= 1'b0;
        end else if (at_crc & ~crc_run & (frame_num[4:0] == tx_fgen_pkg::CRC_FIRST_FRAME)) begin
            crc_run <= 1'b1;
        end else if (at_crc & crc_run & (frame_num[4:0] == tx_fgen_pkg::CRC_LAST_FRAME)) begin
            crc_run <= 1'b0;
        end
    end

    // inject bits: software sets, hardware clears when done; a fresh write wins
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            inject <= 4'h0;
        end else if (wr_go & (idx == tx_fgen_pkg::IDX_INJECT)) begin
            inject <= wdat[3:0];
        end else begin
            inject <= inject & ~done;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            inject_prev <= 4'h0;
            align_prev <= 1'b0;
        end else begin
            inject_prev <= inject;
            align_prev <= align_toggle;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            armed <= 4'h0;
        end else begin
            armed <= ((armed & ~done) | (inject & ~inject_prev)) & inject;
        end
    end

    // alignment shift: rising edge drops a position, falling edge repeats one
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            align_pend <= 1'b0;
            align_dir <= 1'b0;
        end else if (align_toggle != align_prev) begin
            align_pend <= 1'b1;
            align_dir <= align_toggle;
        end else if (in_valid) begin
            align_pend <= 1'b0;
        end
    end

    logic [7:0] step_pos;
    logic [6:0] step_frame;
    logic [1:0] steps;
    always_comb begin
        steps = 2'd1;
        if (align_pend) begin
            steps = align_dir ? 2'd2 : 2'd0;
        end
        step_pos = bit_pos;
        step_frame = frame_num;
        for (int i = 0; i < 2; i++) begin
            if (i < int'(steps)) begin
                if (step_pos == tx_fgen_pkg::LAST_BIT) begin
                    step_pos = 8'd0;
                    step_frame = (step_frame == mf_len(fmt) - 7'd1) ? 7'd0 : step_frame + 7'd1;
                end else begin
                    step_pos = step_pos + 8'd1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bit_pos <= 8'd0;
            frame_num <= 7'd0;
        end else if (in_valid) begin
            bit_pos <= step_pos;
            frame_num <= (step_frame >= mf_len(fmt)) ? 7'd0 : step_frame;
        end
    end

    // f-bit value
    logic f_val;
    always_comb begin
        f_val = in_bit;
        if (gen_on) begin
            unique case (fmt)
                tx_fgen_pkg::FMT_SF,
                tx_fgen_pkg::FMT_DM: begin
                    f_val = odd_frame ? ~pair_idx[0] : tx_fgen_pkg::FS_SF_PAT[pair_idx[2:0]];
                end
                tx_fgen_pkg::FMT_ESF: begin
                    if (esf_phase == tx_fgen_pkg::ESF_FAS_PHASE) begin
                        f_val = tx_fgen_pkg::FAS_ESF_PAT[esf_grp[2:0]];
                    end else if (odd_frame & yellow) begin
                        f_val = ~dl_cnt[3];
                    end
                end
                tx_fgen_pkg::FMT_SLC: begin
                    if (odd_frame) begin
                        f_val = ~pair_idx[0];
                    end else if (pair_idx < tx_fgen_pkg::SLC_SYNC_LEN) begin
                        f_val = tx_fgen_pkg::SLC_SYNC_PAT[pair_idx[3:0]];
                    end else if (!bypass && pair_idx >= tx_fgen_pkg::SLC_A_FIRST
                                 && pair_idx <= tx_fgen_pkg::SLC_S_LAST) begin
                        // a1,a2 then s1..s4 in order, low bit first
                        f_val = slc_sa[3'(pair_idx - tx_fgen_pkg::SLC_A_FIRST)];
                    end
                end
            endcase
        end
        if (done[tx_fgen_pkg::B_FT] | done[tx_fgen_pkg::B_FS] | (at_crc & (crc_run | armed[tx_fgen_pkg::B_CRC] & (frame_num[4:0] == tx_fgen_pkg::CRC_FIRST_FRAME)))) begin
            f_val = ~f_val;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dl_cnt <= 4'h0;
        end else if (in_valid & f_pos & odd_frame & (fmt == tx_fgen_pkg::FMT_ESF)) begin
            dl_cnt <= dl_cnt + 4'h1;
        end
    end

    // outgoing bit
    logic next_bit;
    always_comb begin
        next_bit = in_bit;
        if (f_pos) begin
            next_bit = f_val;
        end else if (gen_on & copy_en & (bit_pos == 8'd1)) begin
            next_bit = last_f;
        end else if (sf_like & yellow & (bit_pos[2:0] == tx_fgen_pkg::YEL_BIT)) begin
            next_bit = 1'b0;
        end
        if (at_dds & (dds_go | (bit_pos == tx_fgen_pkg::DDS_FIRST))) begin
            next_bit = ~next_bit;
        end
        if (force_ones) begin
            next_bit = 1'b1;
        end else if (force_zeros) begin
            next_bit = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            last_f <= 1'b0;
        end else if (in_valid & f_pos) begin
            last_f <= f_val;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            out_valid <= 1'b0;
            out_bit <= 1'b0;
        end else begin
            out_valid <= in_valid;
            out_bit <= in_valid ? next_bit : out_bit;
        end
    end

    // start flags: a set in the same cycle as a write-one clear wins
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flags <= 2'h0;
        end else begin
            flags[tx_fgen_pkg::B_MFS] <= mf_first
                | (flags[tx_fgen_pkg::B_MFS]
                   & ~(wr_go & (idx == tx_fgen_pkg::IDX_IRQ_FLAGS) & wdat[tx_fgen_pkg::B_MFS]));
            flags[tx_fgen_pkg::B_BFS] <= frame_first
                | (flags[tx_fgen_pkg::B_BFS]
                   & ~(wr_go & (idx == tx_fgen_pkg::IDX_IRQ_FLAGS) & wdat[tx_fgen_pkg::B_BFS]));
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags & irq_en);
        end
    end
endmodule
`default_nettype wire

// File: logic/tx_fgen_pkg.sv
// shared constants for the t1 transmit frame maintenance and error injection block
package tx_fgen_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_MODE = 8'h62;
    localparam logic [7:0] IDX_SLC_SA = 8'h67;
    localparam logic [7:0] IDX_ALARM = 8'h6B;
    localparam logic [7:0] IDX_OVERWRITE = 8'h6C;
    localparam logic [7:0] IDX_IRQ_EN = 8'h6D;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h6E;
    localparam logic [7:0] IDX_INJECT = 8'h6F;
    localparam int ADDR_W = 10;

    // field positions
    localparam int B_GEN_OFF = 0;
    localparam int B_BYPASS = 2;
    localparam int B_FMT_LO = 4;
    localparam int B_MANUAL_YEL = 0;
    localparam int B_AUTO_YEL = 1;
    localparam int B_FORCE_ONES = 0;
    localparam int B_FORCE_ZEROS = 1;
    localparam int B_ALIGN = 2;
    localparam int B_COPY = 3;
    localparam int B_BFS = 0;
    localparam int B_MFS = 1;
    localparam int B_FT = 0;
    localparam int B_FS = 1;
    localparam int B_CRC = 2;
    localparam int B_DDS = 3;

    typedef enum logic [1:0] {
        FMT_SF = 2'b00,
        FMT_ESF = 2'b01,
        FMT_DM = 2'b10,
        FMT_SLC = 2'b11
    } frame_fmt_e;

    // frame geometry
    localparam logic [7:0] LAST_BIT = 8'd192;
    localparam logic [6:0] MF_SF = 7'd12;
    localparam logic [6:0] MF_ESF = 7'd24;
    localparam logic [6:0] MF_SLC = 7'd72;
    localparam logic [7:0] DDS_FIRST = 8'd185;
    localparam logic [7:0] DDS_LAST = 8'd190;
    localparam logic [2:0] YEL_BIT = 3'h2;

    // f-bit patterns, bit n is the n-th occurrence
    localparam logic [5:0] FS_SF_PAT = 6'h1C;
    localparam logic [5:0] FAS_ESF_PAT = 6'h34;
    localparam logic [11:0] SLC_SYNC_PAT = 12'hE38;
    localparam logic [5:0] SLC_SYNC_LEN = 6'd12;
    localparam logic [5:0] SLC_A_FIRST = 6'd27;
    localparam logic [5:0] SLC_S_FIRST = 6'd29;
    localparam logic [5:0] SLC_S_LAST = 6'd32;
    localparam logic [4:0] CRC_FIRST_FRAME = 5'd1;
    localparam logic [4:0] CRC_LAST_FRAME = 5'd21;
    localparam logic [1:0] ESF_FAS_PHASE = 2'd3;
    localparam logic [1:0] ESF_CRC_PHASE = 2'd1;
endpackage

// File: dv/tx_line_model.sv
// downstream line partner: feeds the transmit stream and records every bit sent
`timescale 1ns/1ps
`default_nettype none
module tx_line_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic fill,
    input wire logic out_valid,
    input wire logic out_bit,
    output logic in_valid,
    output logic in_bit
);
    logic line_mem [0:8191];
    int rx_cnt;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            in_valid <= 1'b0;
            in_bit <= 1'b0;
        end else begin
            in_valid <= run;
            // between bits the data line keeps changing so stale data never looks valid
            in_bit <= run ? fill : ~in_bit;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rx_cnt <= 0;
        end else if (out_valid) begin
            line_mem[rx_cnt[12:0]] <= out_bit;
            rx_cnt <= rx_cnt + 1;
        end
    end
endmodule
`default_nettype wire

// File: dv/tx_frame_maint_props.sv
// port-level assertion checker for the frame maintenance block
`timescale 1ns/1ps
`default_nettype none
module tx_frame_maint_props (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic red_alarm,
    input wire logic in_valid,
    input wire logic in_bit,
    input wire logic out_valid,
    input wire logic out_bit,
    input wire logic irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic [7:0] ovr;
    logic [7:0] ena;
    wire logic [7:0] idx = avs_address[9:2];
    wire logic done = (avs_read || avs_write) && !avs_waitrequest;
    // shadow copies change at the same edge as the real registers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ovr <= 8'h00;
            ena <= 8'h00;
        end else if (avs_write && !avs_waitrequest) begin
            if (idx == tx_fgen_pkg::IDX_OVERWRITE) ovr <= avs_writedata[7:0];
            if (idx == tx_fgen_pkg::IDX_IRQ_EN) ena <= avs_writedata[7:0];
        end
    end
    sequence s_answer;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    a_wait_first: assert property (($rose(avs_read) || $rose(avs_write)) |-> s_answer)
        else $error("request not answered in its second cycle");
    a_wait_once: assert property (done |=> !done)
        else $error("waitrequest low for more than one cycle");
    a_valid_delay: assert property (out_valid == $past(in_valid))
        else $error("out_valid is not in_valid delayed by one cycle");
    a_bit_holds: assert property (!in_valid |=> $stable(out_bit))
        else $error("out_bit changed without a strobe");
    a_force_ones: assert property (in_valid && ovr[0] |=> out_bit)
        else $error("forced ones not sent");
    a_force_zeros: assert property (in_valid && ovr[1] && !ovr[0] |=> !out_bit)
        else $error("forced zeros not sent");
    a_irq_masked: assert property (ena[1:0] == 2'b00 |=> !irq)
        else $error("irq raised with both enables clear");
    a_ctrl_readback: assert property (done && avs_read && idx == tx_fgen_pkg::IDX_OVERWRITE
        |-> avs_readdata == {28'h0, ovr[3:0]})
        else $error("overwrite control reads back wrong");
    a_unmapped_zero: assert property (done && avs_read
        && !(idx inside {8'h62, 8'h67, [8'h6B:8'h6F]}) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind tx_frame_maint tx_frame_maint_props tx_frame_maint_props_inst (.core_clk(core_clk),
    .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .red_alarm(red_alarm), .in_valid(in_valid),
    .in_bit(in_bit), .out_valid(out_valid), .out_bit(out_bit), .irq(irq));
`default_nettype wire

// File: dv/tx_frame_maint_tb_top.sv
// self-checking bench for the frame maintenance block
`timescale 1ns/1ps
`default_nettype none
module tx_frame_maint_tb_top;
    logic core_clk, rst_b, avs_read, avs_write, avs_waitrequest, red_alarm;
    logic in_valid, in_bit, out_valid, out_bit, irq, run, fill;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [7:0] ridx [0:4];
    logic [7:0] rmsk [0:4];
    int num_errors, num_checks, flip_idx, c, f1, dlo;
    tx_frame_maint tx_frame_maint_inst (.core_clk(core_clk), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .red_alarm(red_alarm), .in_valid(in_valid),
        .in_bit(in_bit), .out_valid(out_valid), .out_bit(out_bit), .irq(irq));
    tx_line_model tx_line_model_inst (.core_clk(core_clk), .rst_b(rst_b), .run(run),
        .fill(fill), .out_valid(out_valid), .out_bit(out_bit), .in_valid(in_valid),
        .in_bit(in_bit));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) check("waitrequest", 32'h1, 32'h0);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check($sformatf("register %h", idx), rd, {24'h0, exp});
    endtask
    // run high for n edges gives exactly n strobes; the tail lets the line model catch up
    task automatic stream(input int n);
        @(posedge core_clk);
        run <= 1'b1;
        repeat (n) @(posedge core_clk);
        run <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic flag_step(input int n, input logic [7:0] exp);
        stream(n);
        rd_chk(tx_fgen_pkg::IDX_IRQ_FLAGS, exp);
    endtask
    // m: b0 yellow, b1 f-bit copy, b2 framing off; frc: b1 forced, b0 forced value
    task automatic chunk(input int n, input logic fv, input logic [2:0] m,
        input logic [1:0] frc);
        int base, pos, fr, k;
        logic e, fb;
        fill <= fv;
        base = tx_line_model_inst.rx_cnt;
        stream(n);
        for (int i = base; i < base + n; i++) begin
            pos = i % 193;
            fr = (i / 193) % 12;
            k = fr / 2;
            fb = fr[0] ? tx_fgen_pkg::FS_SF_PAT[k] : !k[0];
            e = fv;
            if (pos == 0 && !m[2]) e = fb;
            if (pos == 1 && m[1]) e = fb;
            if (pos % 8 == 2 && m[0]) e = 1'b0;
            if (i == flip_idx) e = !e;
            if (i >= dlo && i < dlo + 6) e = !e;
            if (frc[1]) e = frc[0];
            check($sformatf("line bit %0d", i), 32'(tx_line_model_inst.line_mem[i]), 32'(e));
        end
    endtask
    function automatic int next_f(input int at, input int par);
        int i;
        i = ((at + 192) / 193) * 193;
        while ((i / 193) % 2 != par) i += 193;
        return i;
    endfunction
    initial begin
        num_errors = 0;
        num_checks = 0;
        flip_idx = -1;
        dlo = -10;
        rst_b = 1'b0;
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        red_alarm = 1'b0;
        run = 1'b0;
        fill = 1'b0;
        ridx = '{tx_fgen_pkg::IDX_MODE, tx_fgen_pkg::IDX_SLC_SA, tx_fgen_pkg::IDX_ALARM,
            tx_fgen_pkg::IDX_IRQ_EN, tx_fgen_pkg::IDX_OVERWRITE};
        rmsk = '{8'h35, 8'h3F, 8'h03, 8'h03, 8'h0B};
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        // alignment bit stays clear here: toggling it would move the frame
        for (int i = 0; i < 5; i++) begin
            rd_chk(ridx[i], 8'h00);
            wr(ridx[i], (i == 4) ? 8'hFB : 8'hFF);
            rd_chk(ridx[i], rmsk[i]);
            wr(ridx[i], 8'h00);
        end
        rd_chk(tx_fgen_pkg::IDX_INJECT, 8'h00);
        wr(tx_fgen_pkg::IDX_IRQ_FLAGS, 8'hFF);
        rd_chk(tx_fgen_pkg::IDX_IRQ_FLAGS, 8'h00);
        wr(8'h60, 8'hFF);
        rd_chk(8'h60, 8'h00);
        wr(tx_fgen_pkg::IDX_IRQ_EN, 8'h03);
        chunk(194, 1'b1, 3'b000, 2'b00);
        rd_chk(tx_fgen_pkg::IDX_IRQ_FLAGS, 8'h03);
        check("irq", irq, 32'h1);
        wr(tx_fgen_pkg::IDX_IRQ_FLAGS, 8'h01);
        rd_chk(tx_fgen_pkg::IDX_IRQ_FLAGS, 8'h02);
        wr(tx_fgen_pkg::IDX_IRQ_EN, 8'h01);
        repeat (2) @(posedge core_clk);
        check("irq", irq, 32'h0);
        wr(tx_fgen_pkg::IDX_IRQ_FLAGS, 8'h02);
        rd_chk(tx_fgen_pkg::IDX_IRQ_FLAGS, 8'h00);
        wr(tx_fgen_pkg::IDX_OVERWRITE, 8'h01);
        chunk(10, 1'b0, 3'b000, 2'b11);
        wr(tx_fgen_pkg::IDX_OVERWRITE, 8'h03);
        chunk(10, 1'b0, 3'b000, 2'b11);
        wr(tx_fgen_pkg::IDX_OVERWRITE, 8'h02);
        chunk(10, 1'b1, 3'b000, 2'b10);
        wr(tx_fgen_pkg::IDX_OVERWRITE, 8'h00);
        chunk(10, 1'b1, 3'b000, 2'b00);
        wr(tx_fgen_pkg::IDX_ALARM, 8'h01);
        chunk(24, 1'b1, 3'b001, 2'b00);
        wr(tx_fgen_pkg::IDX_ALARM, 8'h02);
        chunk(24, 1'b1, 3'b000, 2'b00);
        red_alarm <= 1'b1;
        chunk(24, 1'b1, 3'b001, 2'b00);
        wr(tx_fgen_pkg::IDX_ALARM, 8'h00);
        chunk(24, 1'b1, 3'b000, 2'b00);
        red_alarm <= 1'b0;
        wr(tx_fgen_pkg::IDX_OVERWRITE, 8'h08);
        chunk(200, 1'b1, 3'b010, 2'b00);
        wr(tx_fgen_pkg::IDX_OVERWRITE, 8'h00);
        for (int p = 0; p < 2; p++) begin
            c = tx_line_model_inst.rx_cnt;
            flip_idx = next_f(c, p);
            wr(tx_fgen_pkg::IDX_INJECT, p ? 8'h02 : 8'h01);
            chunk(flip_idx - c + 2, 1'b1, 3'b000, 2'b00);
            rd_chk(tx_fgen_pkg::IDX_INJECT, 8'h00);
        end
        flip_idx = -1;
        // dm format: one dds pattern of the current frame must come out inverted
        c = tx_line_model_inst.rx_cnt;
        dlo = c - c % 193 + 185;
        wr(tx_fgen_pkg::IDX_MODE, 8'h20);
        wr(tx_fgen_pkg::IDX_INJECT, 8'h08);
        chunk(dlo - c + 6, 1'b1, 3'b000, 2'b00);
        rd_chk(tx_fgen_pkg::IDX_INJECT, 8'h00);
        dlo = -10;
        wr(tx_fgen_pkg::IDX_MODE, 8'h01);
        wr(tx_fgen_pkg::IDX_INJECT, 8'h01);
        chunk(200, 1'b1, 3'b100, 2'b00);
        rd_chk(tx_fgen_pkg::IDX_INJECT, 8'h01);
        wr(tx_fgen_pkg::IDX_MODE, 8'h00);
        c = tx_line_model_inst.rx_cnt;
        flip_idx = next_f(c, 0);
        chunk(flip_idx - c + 2, 1'b1, 3'b000, 2'b00);
        rd_chk(tx_fgen_pkg::IDX_INJECT, 8'h00);
        wr(tx_fgen_pkg::IDX_IRQ_FLAGS, 8'h03);
        c = tx_line_model_inst.rx_cnt;
        f1 = (c / 193 + 1) % 12;
        wr(tx_fgen_pkg::IDX_OVERWRITE, 8'h04);
        flag_step(192 - c % 193, 8'h00);
        flag_step(1, {6'h0, f1 == 0, 1'b1});
        wr(tx_fgen_pkg::IDX_IRQ_FLAGS, 8'h03);
        wr(tx_fgen_pkg::IDX_OVERWRITE, 8'h00);
        flag_step(193, 8'h00);
        flag_step(1, {6'h0, (f1 + 1) % 12 == 0, 1'b1});
        wrap_up;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        check("watchdog", 32'h1, 32'h0);
        wrap_up;
    end
endmodule
`default_nettype wire
